// *** rtl/pbt_timers.v ***
// Purpose: Prescalers, base timer and general timer with APB registers
// Assumes: pclk is the running system clock; crystal and event pins are async
// Notes:   Function
// Function
// - Selectable prescaler: 8-bit, counts when enabled
// - Source bit picks system clock or events
// - Prescaler read returns inverted count
// - Writing clear bit one zeroes prescaler
// - Enable bit zero halts prescaler clock
// - Event mode cascades prescaler with general timer
// - Crystal prescaler runs only on crystal
// - Base timer wrap sets its request
// - Base timer prescaler taps 256/32/8/2
// - Base timer crystal taps 256/64/16/4
// - General timer wrap sets its request
// - General count reads live, write loads
// - General timer stops with system clock
// - General prescaler taps, bit four reload
// - General crystal taps 256/128/64/32
// - Select bit switches RC or crystal
// - Select bit reads actual clock source
// - Warm-up of 16 or 256 cycles
`timescale 1ns/1ps
`default_nettype none
`include "pbt_consts.vh"

module pbt_timers (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Asynchronous inputs
    input  wire        crystal_clock,
    input  wire        external_event_pin,
    // Status
    output reg         sysclk_source_q,
    output reg         base_timer_request,
    output reg         general_timer_request
);

    // ----------------------------------------------------------------
    // Tap selection
    // ----------------------------------------------------------------
    function [2:0] tap_index;
        input [1:0] sel;
        input [11:0] taps;
        begin
            case (sel)
                2'b00:   tap_index = taps[2:0];
                2'b01:   tap_index = taps[5:3];
                2'b10:   tap_index = taps[8:6];
                default: tap_index = taps[11:9];
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // Register index decode
    // ----------------------------------------------------------------
    function idx_is;
        input [9:0] word_idx;
        input [7:0] reg_idx;
        begin
            idx_is = (word_idx == {2'b00, reg_idx});
        end
    endfunction

    // Divider bit per mode code, packed as codes 11, 10, 01, 00
    localparam [11:0] BT_PRE_TAPS  = {3'd0, 3'd2, 3'd4, 3'd7};
    localparam [11:0] BT_XTAL_TAPS = {3'd1, 3'd3, 3'd5, 3'd7};
    localparam [11:0] GT_PRE_TAPS  = {3'd0, 3'd2, 3'd4, 3'd7};
    localparam [11:0] GT_XTAL_TAPS = {3'd4, 3'd5, 3'd6, 3'd7};

    // ----------------------------------------------------------------
    // Synchronisers and edge detectors
    // ----------------------------------------------------------------
    reg [2:0] xtal_sync_q;
    reg [2:0] evt_sync_q;
    wire      xtal_rise = xtal_sync_q[1] & ~xtal_sync_q[2];
    wire      evt_rise  = evt_sync_q[1] & ~evt_sync_q[2];

    // Only stages 1 and 2 feed logic; stage 0 may be metastable
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xtal_sync_q <= 3'h0;
        end else begin
            xtal_sync_q <= {xtal_sync_q[1:0], crystal_clock};
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_sync_q <= 3'h0;
        end else begin
            evt_sync_q <= {evt_sync_q[1:0], external_event_pin};
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg  [7:0] base_mode_q;
    reg  [7:0] gen_mode_q;
    reg        prs_enable_q;
    reg        prs_source_q;
    reg        short_warm_q;
    reg  [5:0] sys_other_q;
    reg        sysclk_source_select_req_q;
    reg  [7:0] reload_q;
    reg        ena_base_q;
    reg        ena_gen_q;
    reg  [7:0] sel_pre_q;
    reg  [7:0] xtal_pre_q;
    reg  [7:0] base_cnt_q;
    reg  [7:0] gen_cnt_q;
    reg  [8:0] warm_q;

    // ----------------------------------------------------------------
    // Register write strobes
    // ----------------------------------------------------------------

    wire [9:0] idx      = paddr[11:2];
    wire       acc      = psel & penable;
    wire       wr       = acc & pwrite;
    wire       w_base   = wr & idx_is(idx, `PBT_IDX_BASE_MODE);
    wire       w_prs    = wr & idx_is(idx, `PBT_IDX_PRESCALER);
    wire       w_gmode  = wr & idx_is(idx, `PBT_IDX_GEN_MODE);
    wire       w_gcnt   = wr & idx_is(idx, `PBT_IDX_GEN_COUNT);
    wire       w_sys    = wr & idx_is(idx, `PBT_IDX_SYS_CTRL);
    wire       w_req    = wr & idx_is(idx, `PBT_IDX_IRQ_REQ);
    wire       w_ena    = wr & idx_is(idx, `PBT_IDX_IRQ_ENA);
    wire       w_clear  = w_prs & pwdata[`PBT_PRS_CLEAR];

    // ----------------------------------------------------------------
    // Prescaler clocks
    // ----------------------------------------------------------------
    // Source pulse: one cycle per system clock or per synced event
    wire       src_pulse = prs_source_q ? evt_rise : 1'b1;
    wire       prescaler_clock_tick = prs_enable_q & src_pulse;
    wire [7:0] sel_pre_inc = sel_pre_q + 8'h01;
    wire [7:0] xtal_pre_inc = xtal_pre_q + 8'h01;
    // Divider output ticks: tick k goes high when bits 0..k all ones
    wire [7:0] sel_carry;
    wire [7:0] xtal_carry;
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_carry
            // Bits 0..g all ones means carry out of bit g
            wire [8:0] low_ones = (9'h1 << (g + 1)) - 9'h1;
            assign sel_carry[g]  = prescaler_clock_tick & (&(sel_pre_q | ~low_ones[7:0]));
            assign xtal_carry[g] = xtal_rise & (&(xtal_pre_q | ~low_ones[7:0]));
        end
    endgenerate
    // Tick for divide by 2^(n+1) is carry out of bit n
    wire [2:0] bt_tap  = tap_index(base_mode_q[1:0],
                           base_mode_q[`PBT_MODE_XTAL] ? BT_XTAL_TAPS : BT_PRE_TAPS);
    wire [2:0] gt_tap  = tap_index(gen_mode_q[1:0],
                           gen_mode_q[`PBT_MODE_XTAL] ? GT_XTAL_TAPS : GT_PRE_TAPS);
    wire bt_tick = base_mode_q[`PBT_MODE_XTAL] ? xtal_carry[bt_tap]
                                               : sel_carry[bt_tap];
    wire gt_tick = gen_mode_q[`PBT_MODE_XTAL] ? xtal_carry[gt_tap]
                                              : sel_carry[gt_tap];

    // ----------------------------------------------------------------
    // Prescaler counters
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_pre_q <= `PBT_RESET_BYTE;
        end else if (w_clear) begin
            sel_pre_q <= `PBT_RESET_BYTE;
        end else if (prescaler_clock_tick) begin
            sel_pre_q <= sel_pre_inc;
        end
    end

    // Crystal prescaler ignores software; only reset stops it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xtal_pre_q <= `PBT_RESET_BYTE;
        end else if (xtal_rise) begin
            xtal_pre_q <= xtal_pre_inc;
        end
    end

    // ----------------------------------------------------------------
    // Base and general timers
    // ----------------------------------------------------------------
    wire       bt_wrap  = bt_tick & (base_cnt_q == 8'hff);
    wire       gt_wrap  = gt_tick & (gen_cnt_q == 8'hff) & ~w_gcnt;
    wire       gt_rel   = gen_mode_q[`PBT_MODE_RELOAD];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_cnt_q <= `PBT_RESET_BYTE;
        end else if (bt_tick) begin
            base_cnt_q <= base_cnt_q + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // General timer
    // ----------------------------------------------------------------
    // Counting runs on pclk only, so it halts with the clock
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen_cnt_q <= `PBT_RESET_BYTE;
            reload_q  <= `PBT_RESET_BYTE;
        end else if (w_gcnt) begin
            gen_cnt_q <= pwdata[7:0];
            reload_q  <= pwdata[7:0];
        end else if (gt_wrap && gt_rel) begin
            gen_cnt_q <= reload_q;
        end else if (gt_tick) begin
            gen_cnt_q <= gen_cnt_q + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // Requests: hardware set wins over software clear
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_timer_request <= 1'b0;
        end else if (bt_wrap) begin
            base_timer_request <= 1'b1;
        end else if (w_req) begin
            base_timer_request <= pwdata[`PBT_REQ_BASE];
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            general_timer_request <= 1'b0;
        end else if (gt_wrap) begin
            general_timer_request <= 1'b1;
        end else if (w_req) begin
            general_timer_request <= pwdata[`PBT_REQ_GEN];
        end
    end

    // ----------------------------------------------------------------
    // Interrupt enables
    // ----------------------------------------------------------------
    // Stored only; no interrupt logic lives in this block
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ena_base_q <= 1'b0;
            ena_gen_q  <= 1'b0;
        end else if (w_ena) begin
            ena_base_q <= pwdata[`PBT_REQ_BASE];
            ena_gen_q  <= pwdata[`PBT_REQ_GEN];
        end
    end

    // ----------------------------------------------------------------
    // Control registers and clock switch warm-up
    // ----------------------------------------------------------------
    wire [8:0] warm_len = short_warm_q ? `PBT_WARM_SHORT : `PBT_WARM_LONG;
    // Warm-up counts cycles of the oscillator being switched to
    wire       osc_tick = sysclk_source_select_req_q ? xtal_rise : 1'b1;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_mode_q <= `PBT_RESET_BYTE;
            gen_mode_q  <= `PBT_RESET_BYTE;
        end else begin
            if (w_base)
                base_mode_q <= {4'h0, pwdata[3], 1'b0, pwdata[1:0]};
            if (w_gmode)
                gen_mode_q <= {3'h0, pwdata[4:3], 1'b0, pwdata[1:0]};
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prs_enable_q <= 1'b0;
            prs_source_q <= 1'b0;
        end else if (w_prs) begin
            prs_enable_q <= pwdata[`PBT_PRS_ENABLE];
            prs_source_q <= pwdata[`PBT_PRS_SOURCE];
        end
    end

    // ----------------------------------------------------------------
    // System clock select and warm-up
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            short_warm_q <= 1'b0;
            sys_other_q  <= 6'h00;
            sysclk_source_select_req_q   <= 1'b0;
        end else if (w_sys) begin
            sysclk_source_select_req_q   <= pwdata[`PBT_SYS_XSRC];
            short_warm_q <= pwdata[`PBT_SYS_SHORT_WARM];
            sys_other_q  <= {pwdata[6:4], pwdata[2], 2'b00};
        end
    end

    // Source flips on the last of the full count of target cycles
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            warm_q          <= 9'h000;
            sysclk_source_q <= 1'b0;
        end else if (w_sys) begin
            if (pwdata[`PBT_SYS_XSRC] != sysclk_source_q)
                warm_q <= 9'h000;
        end else if (sysclk_source_select_req_q != sysclk_source_q && osc_tick) begin
            if (warm_q >= warm_len - 9'h001) begin
                sysclk_source_q <= sysclk_source_select_req_q;
                warm_q          <= 9'h000;
            end else begin
                warm_q <= warm_q + 9'h001;
            end
        end
    end

    // ----------------------------------------------------------------
    // APB read and response
    // ----------------------------------------------------------------
    reg [7:0] rd_byte;
    reg       rd_hit;
    always @* begin
        rd_byte = 8'h00;
        rd_hit  = 1'b1;
        case (idx)
            {2'b00, `PBT_IDX_BASE_MODE}: rd_byte = 8'h00;
            {2'b00, `PBT_IDX_PRESCALER}: rd_byte = ~sel_pre_q;
            {2'b00, `PBT_IDX_GEN_MODE}:  rd_byte = gen_mode_q;
            {2'b00, `PBT_IDX_GEN_COUNT}: rd_byte = gen_cnt_q;
            {2'b00, `PBT_IDX_SYS_CTRL}:  rd_byte = {sysclk_source_q, sys_other_q[5:3],
                                                     short_warm_q, sys_other_q[2], 2'b00};
            {2'b00, `PBT_IDX_IRQ_REQ}:   rd_byte = {2'b00, base_timer_request, 1'b0,
                                                     general_timer_request, 3'b000};
            {2'b00, `PBT_IDX_IRQ_ENA}:   rd_byte = {2'b00, ena_base_q, 1'b0, ena_gen_q, 3'b000};
            default:                     rd_hit  = 1'b0;
        endcase
    end

    // Setup phase seen now, so the answer stands in the access phase
    wire setup_ph = psel & ~penable;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup_ph;
            pslverr <= setup_ph & ~rd_hit;
        end
    end

    // Read data is zero outside a read answer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_ph & ~pwrite) begin
            prdata <= {24'h000000, rd_byte};
        end else begin
            prdata <= 32'h0000_0000;
        end
    end

endmodule
`default_nettype wire

// *** include/pbt_consts.vh ***
// Purpose: Constants for the prescaled base and event timer block
// Assumes: APB byte addresses are four times the register index
// Notes:   Definitions only
`ifndef PBT_CONSTS_VH
`define PBT_CONSTS_VH

// Register indices; byte address is index times four
`define PBT_IDX_BASE_MODE   8'h21
`define PBT_IDX_PRESCALER   8'h23
`define PBT_IDX_GEN_MODE    8'h26
`define PBT_IDX_GEN_COUNT   8'h27
`define PBT_IDX_SYS_CTRL    8'h30
`define PBT_IDX_IRQ_REQ     8'h3c
`define PBT_IDX_IRQ_ENA     8'h3e

// Field positions
`define PBT_PRS_CLEAR       7
`define PBT_PRS_ENABLE      6
`define PBT_PRS_SOURCE      5
`define PBT_MODE_XTAL       3
`define PBT_MODE_RELOAD     4
`define PBT_SYS_XSRC        7
`define PBT_SYS_SHORT_WARM  3
`define PBT_REQ_BASE        5
`define PBT_REQ_GEN         3

// Reset values
`define PBT_RESET_BYTE      8'h00

// Warm-up lengths in oscillation cycles
`define PBT_WARM_SHORT      9'd16
`define PBT_WARM_LONG       9'd256

`endif

// *** dv/pbt_timers_checker.sv ***
// Purpose: Port-level assertions for pbt_timers
// Assumes: Single pclk domain, presetn async active low
// Notes:   Bound to every pbt_timers instance
`timescale 1ns/1ps
`default_nettype none
module pbt_timers_checker (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins and status
    input wire logic        crystal_clock,
    input wire logic        external_event_pin,
    input wire logic        sysclk_source_q,
    input wire logic        base_timer_request,
    input wire logic        general_timer_request
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire req_wr = pready && pwrite && paddr == 12'h0f0;
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held over two cycles");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_setup_answer: assert property (psel && !penable |=> pready)
        else $error("access phase not answered at once");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    a_base_sticky: assert property (base_timer_request && !req_wr |=> base_timer_request)
        else $error("base request dropped without write");
    a_gen_sticky: assert property (general_timer_request && !req_wr |=> general_timer_request)
        else $error("general request dropped without write");
endmodule
bind pbt_timers pbt_timers_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .crystal_clock(crystal_clock),
    .external_event_pin(external_event_pin), .sysclk_source_q(sysclk_source_q),
    .base_timer_request(base_timer_request), .general_timer_request(general_timer_request));
`default_nettype wire

// *** dv/tb.sv ***
// Purpose: Self-checking register-level bench for pbt_timers
// Assumes: Wait-free APB slave, crystal input at one twentieth of pclk
// Notes:   Directed sequence of APB calls
`timescale 1ns/1ps
`default_nettype none
`include "pbt_consts.vh"
module tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, src_q, base_req, gen_req;
    logic xtal = 0, evt = 0;
    logic [7:0] r, a;
    logic e;
    int err_count = 0, n_compared = 0, n;
    wire [2:0] flags = {src_q, gen_req, base_req};
    logic [7:0] idx [7] = '{8'h21, 8'h23, 8'h26, 8'h27, 8'h30, 8'h3c, 8'h3e};
    logic [7:0] rst [7] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    pbt_timers dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .crystal_clock(xtal), .external_event_pin(evt),
        .sysclk_source_q(src_q), .base_timer_request(base_req), .general_timer_request(gen_req));
    always #5 pclk = ~pclk;
    always begin
        repeat (10) @(posedge pclk);
        xtal <= ~xtal;
    end
    function automatic [11:0] ba(input [7:0] i);
        ba = {2'b00, i, 2'b00};
    endfunction
    task automatic apb(input logic w, input [7:0] i, input [7:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= ba(i); pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata[7:0];
        e = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic chk(input [31:0] seen, input [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_lvl(input int b, input logic v, output int c);
        c = 0;
        while (flags[b] !== v && c < 30000) begin
            @(posedge pclk);
            c++;
        end
    endtask
    task automatic final_report;
        if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge pclk);
        err_count++;
        final_report();
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        // Reset values
        for (int k = 0; k < 7; k++) begin
            apb(0, idx[k], 8'h0);
            chk({e, r}, {1'b0, rst[k]}, "reset value");
        end
        apb(0, 8'h00, 8'h0);
        chk({e, r}, 9'h100, "unmapped read");
        apb(1, `PBT_IDX_GEN_COUNT, 8'h5a);
        apb(0, `PBT_IDX_GEN_COUNT, 8'h0);
        chk(r, 8'h5a, "gen count load");
        // Prescaler /2 into general timer
        apb(1, `PBT_IDX_PRESCALER, 8'h40);
        apb(1, `PBT_IDX_GEN_MODE, 8'h03);
        apb(1, `PBT_IDX_GEN_COUNT, 8'hf0);
        wait_lvl(1, 1, n);
        chk(n >= 28 && n <= 40, 1, "gen wrap time");
        apb(1, `PBT_IDX_IRQ_REQ, 8'h00);
        apb(1, `PBT_IDX_GEN_MODE, 8'h13);
        apb(1, `PBT_IDX_GEN_COUNT, 8'hfe);
        wait_lvl(1, 1, n);
        apb(0, `PBT_IDX_GEN_COUNT, 8'h0);
        chk(r[7:1], 7'h7f, "reload value");
        // Halt, clear, event counting
        apb(1, `PBT_IDX_PRESCALER, 8'h00);
        apb(0, `PBT_IDX_PRESCALER, 8'h0);
        a = r;
        repeat (10) @(posedge pclk);
        apb(0, `PBT_IDX_PRESCALER, 8'h0);
        chk(r, a, "halted prescaler");
        apb(1, `PBT_IDX_PRESCALER, 8'h80);
        apb(0, `PBT_IDX_PRESCALER, 8'h0);
        chk(r, 8'hff, "cleared prescaler");
        apb(1, `PBT_IDX_PRESCALER, 8'he0);
        repeat (5) begin
            repeat (4) @(posedge pclk);
            evt <= 1;
            repeat (4) @(posedge pclk);
            evt <= 0;
        end
        repeat (6) @(posedge pclk);
        apb(0, `PBT_IDX_PRESCALER, 8'h0);
        chk(r, 8'hfa, "event count");
        // Base timer from crystal /4 with prescaler off
        apb(1, `PBT_IDX_PRESCALER, 8'h00);
        apb(1, `PBT_IDX_IRQ_REQ, 8'h00);
        apb(0, `PBT_IDX_IRQ_REQ, 8'h0);
        chk(r, 8'h00, "requests cleared");
        apb(1, `PBT_IDX_BASE_MODE, 8'h0b);
        wait_lvl(0, 1, n);
        chk(n >= 20000 && n <= 21000, 1, "base wrap time");
        // Clock switch with short warm-up
        apb(1, `PBT_IDX_SYS_CTRL, 8'h88);
        apb(0, `PBT_IDX_SYS_CTRL, 8'h0);
        chk(r[7], 1'b0, "source before warm-up");
        wait_lvl(2, 1, n);
        chk(n >= 290 && n <= 340, 1, "crystal warm-up");
        apb(0, `PBT_IDX_SYS_CTRL, 8'h0);
        chk(r, 8'h88, "source after warm-up");
        apb(1, `PBT_IDX_SYS_CTRL, 8'h08);
        wait_lvl(2, 0, n);
        chk(n >= 13 && n <= 20, 1, "rc warm-up");
        final_report();
    end
endmodule
`default_nettype wire
